// File: logic/urad_receiver.sv
/*
  Asynchronous serial receiver back end with a two-character buffer,
  overrun stall, nine-bit characters and address filtering, reached over
  AXI4-Lite. Assumes the line input is already synchronous to core_clk.
*/
`timescale 1ns/10ps
`default_nettype none
`include "urad_regs.svh"
module urad_receiver
  import urad_pkg::*;
(
  input  wire logic             core_clk,
  input  wire logic             reset,
  input  wire urad_axi_req_type axi_req,
  output var  urad_axi_rsp_type axi_rsp,
  input  wire logic             rx_line,
  output var  logic             rx_irq
);

  urad_regs_type  st_reg;
  urad_regs_type  st_next;
  logic           en;
  logic           push;
  logic           pop;
  logic           done;
  logic           ovf;
  logic           vote;
  logic           ninth;
  logic           wr_idx;
  logic [15:0]    div_eff;
  logic [3:0]     last_bit;
  logic [7:0]     rbyte;
  urad_entry_type top;
  urad_entry_type entry;

  // Majority of three samples taken around the bit centre.
  function automatic logic vote3(input logic [2:0] s);
    vote3 = (s[0] & s[1]) | (s[0] & s[2]) | (s[1] & s[2]);
  endfunction : vote3

  // Address decode shared by the read and the write path.
  function automatic logic mapped(input logic [7:0] a);
    mapped = (a == `URAD_OFF_RSC) || (a == `URAD_OFF_RDATA) ||
             (a == `URAD_OFF_TSC) || (a == `URAD_OFF_BCTL) ||
             (a == `URAD_OFF_DIVL) || (a == `URAD_OFF_DIVH) ||
             (a == `URAD_OFF_INTCTL);
  endfunction : mapped

  assign axi_rsp = st_reg.axi;
  assign rx_irq  = st_reg.irq;

  // Next state of the whole block: bus slave, baud tick, sampler, buffer.
  always_comb begin
    st_next = st_reg;
    push    = 1'b0;
    pop     = 1'b0;
    done    = 1'b0;
    ovf     = 1'b0;
    vote    = 1'b0;
    rbyte   = 8'h00;
    en      = st_reg.rsc[`URAD_RC_PEN] & st_reg.rsc[`URAD_RC_REN] &
              ~st_reg.tsc[`URAD_TX_SYNC];
    div_eff = st_reg.bctl[`URAD_BC_WIDE] ? st_reg.divisor :
              {8'h00, st_reg.divisor[7:0]};
    last_bit = st_reg.rsc[`URAD_RC_NINE] ? `URAD_LAST_BIT9 :
               `URAD_LAST_BIT8;
    top     = st_reg.fifo[st_reg.rd_ptr];
    ninth   = st_reg.rsc[`URAD_RC_NINE] & st_reg.shift[8];
    entry   = '0;
    wr_idx  = st_reg.rd_ptr ^ st_reg.count[0];

    // Write channels are taken independently; the write acts once both are in.
    if (axi_req.awvalid && st_reg.axi.awready) begin
      st_next.aw_have = 1'b1;
      st_next.waddr   = axi_req.awaddr;
    end
    if (axi_req.wvalid && st_reg.axi.wready) begin
      st_next.w_have = 1'b1;
      st_next.wbyte  = axi_req.wdata[7:0];
      st_next.wen0   = axi_req.wstrb[0];
    end
    if (st_reg.axi.bvalid && axi_req.bready) begin
      st_next.axi.bvalid = 1'b0;
    end
    if (st_reg.aw_have && st_reg.w_have && !st_reg.axi.bvalid) begin
      st_next.aw_have    = 1'b0;
      st_next.w_have     = 1'b0;
      st_next.axi.bvalid = 1'b1;
      st_next.axi.bresp  = mapped(st_reg.waddr) ? `URAD_RESP_OKAY :
                           `URAD_RESP_SLVERR;
      if (st_reg.wen0) begin
        case (st_reg.waddr)
          `URAD_OFF_RSC: begin
            st_next.rsc = st_reg.wbyte & `URAD_RSC_WMASK;
          end
          `URAD_OFF_TSC: begin
            st_next.tsc = st_reg.wbyte & `URAD_TSC_WMASK;
          end
          `URAD_OFF_BCTL: begin
            st_next.bctl = st_reg.wbyte & `URAD_BCTL_WMASK;
          end
          `URAD_OFF_DIVL: begin
            st_next.divisor[7:0] = st_reg.wbyte;
          end
          `URAD_OFF_DIVH: begin
            st_next.divisor[15:8] = st_reg.wbyte;
          end
          `URAD_OFF_INTCTL: begin
            st_next.rx_ie = st_reg.wbyte[0];
          end
          default: begin
          end
        endcase
      end
    end

    // Reads answer from live state; a data read advances the buffer.
    if (st_reg.axi.rvalid && axi_req.rready) begin
      st_next.axi.rvalid = 1'b0;
    end
    if (axi_req.arvalid && st_reg.axi.arready) begin
      case (axi_req.araddr)
        `URAD_OFF_RSC: begin
          rbyte = {st_reg.rsc[7:3], top.frame_err & (st_reg.count != 2'h0),
                   st_reg.overrun,
                   top.data[8] & (st_reg.count != 2'h0)};
        end
        `URAD_OFF_RDATA: begin
          rbyte = top.data[7:0];
          pop   = (st_reg.count != 2'h0);
        end
        `URAD_OFF_TSC: begin
          rbyte = st_reg.tsc | (8'h01 << `URAD_TX_TRMT);
        end
        `URAD_OFF_BCTL: begin
          rbyte = st_reg.bctl |
                  ({7'h00, st_reg.rx_state == URAD_IDLE} << `URAD_BC_IDLE);
        end
        `URAD_OFF_DIVL: begin
          rbyte = st_reg.divisor[7:0];
        end
        `URAD_OFF_DIVH: begin
          rbyte = st_reg.divisor[15:8];
        end
        `URAD_OFF_INTCTL: begin
          rbyte = {6'h00, st_reg.rx_ready, st_reg.rx_ie};
        end
        default: begin
          rbyte = 8'h00;
        end
      endcase
      st_next.axi.rvalid = 1'b1;
      st_next.axi.rdata  = {24'h000000, rbyte};
      st_next.axi.rresp  = mapped(axi_req.araddr) ? `URAD_RESP_OKAY :
                           `URAD_RESP_SLVERR;
    end

    // Divisor counter gives one sample tick every div_eff plus one cycles: the low byte alone, or all sixteen bits when wide.
    st_next.tick = 1'b0;
    if (!en) begin
      st_next.brg_cnt = 16'h0000;
    end else if (st_reg.brg_cnt == 16'h0000) begin
      st_next.brg_cnt = div_eff;
      st_next.tick    = 1'b1;
    end else begin
      st_next.brg_cnt = st_reg.brg_cnt - 16'h0001;
    end

    // Sampler: sixteen ticks per bit, votes at ticks seven to nine.
    st_next.rx_prev = rx_line;
    case (st_reg.rx_state)
      URAD_IDLE: begin
        if (en && st_reg.rx_prev && !rx_line) begin
          st_next.rx_state = URAD_START;
          st_next.tcnt     = 4'h0;
        end
      end
      URAD_START: begin
        if (st_reg.tick) begin
          st_next.tcnt = st_reg.tcnt + 4'h1;
          if (st_reg.tcnt == `URAD_T_HALF && rx_line) begin
            st_next.rx_state = URAD_IDLE;
          end else if (st_reg.tcnt == `URAD_T_LAST) begin
            st_next.rx_state = URAD_DATA;
            st_next.bit_idx  = 4'h0;
          end
        end
      end
      URAD_DATA, URAD_STOP: begin
        if (st_reg.tick) begin
          st_next.tcnt = st_reg.tcnt + 4'h1;
          vote = vote3({st_reg.votes, rx_line});
          if (st_reg.tcnt == `URAD_T_VOTE_A ||
              st_reg.tcnt == `URAD_T_VOTE_B) begin
            st_next.votes = {st_reg.votes[0], rx_line};
          end
          if (st_reg.rx_state == URAD_STOP) begin
            if (st_reg.tcnt == `URAD_T_VOTE_C) begin
              done             = 1'b1;
              st_next.rx_state = URAD_IDLE;
            end
          end else begin
            if (st_reg.tcnt == `URAD_T_VOTE_C) begin
              st_next.shift[st_reg.bit_idx] = vote;
            end
            if (st_reg.tcnt == `URAD_T_LAST) begin
              if (st_reg.bit_idx == last_bit) begin
                st_next.rx_state = URAD_STOP;
              end else begin
                st_next.bit_idx = st_reg.bit_idx + 4'h1;
              end
            end
          end
        end
      end
      default: begin
        st_next.rx_state = URAD_IDLE;
      end
    endcase
    if (!en) begin
      st_next.rx_state = URAD_IDLE;
    end

    // Clears act first so that an overrun found in the same cycle survives.
    if (!st_next.rsc[`URAD_RC_REN]) begin
      st_next.overrun = 1'b0;
    end
    if (!st_next.rsc[`URAD_RC_PEN]) begin
      st_next.overrun = 1'b0;
      st_next.count  = 2'h0;
      st_next.rd_ptr = 1'b0;
      pop            = 1'b0;
    end

    // A finished character is dropped, flagged as overrun or stored.
    entry = '{frame_err: ~vote, data: {ninth, st_reg.shift[7:0]}};
    if (done && st_next.rsc[`URAD_RC_PEN]) begin
      if (st_reg.overrun) begin
        push = 1'b0;
      end else if (st_reg.rsc[`URAD_RC_AEN] && !ninth) begin
        push = 1'b0;
      end else if (st_reg.count == `URAD_FIFO_DEPTH && !pop) begin
        ovf             = 1'b1;
        st_next.overrun = 1'b1;
      end else begin
        push = 1'b1;
      end
    end
    if (push) begin
      st_next.fifo[wr_idx] = entry;
    end
    if (pop) begin
      st_next.rd_ptr = ~st_reg.rd_ptr;
    end
    if (st_next.rsc[`URAD_RC_PEN]) begin
      st_next.count = st_reg.count + {1'b0, push} - {1'b0, pop};
    end

    // Ready flag follows the buffer; the request is gated by its enable.
    st_next.rx_ready = (st_next.count != 2'h0) &&
                       st_next.rsc[`URAD_RC_PEN];
    st_next.irq      = st_next.rx_ready & st_next.rx_ie;

    // One write and one read at a time: readiness drops while busy.
    st_next.axi.awready = ~st_next.aw_have & ~st_next.axi.bvalid;
    st_next.axi.wready  = ~st_next.w_have & ~st_next.axi.bvalid;
    st_next.axi.arready = ~st_next.axi.rvalid;
  end

  // All state is registered here; the record resets to zero.
  always_ff @(posedge core_clk) begin
    if (reset) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (reset);

  AST_FIFO_MAX: assert property (st_reg.count <= `URAD_FIFO_DEPTH)
    else $error("buffer holds more than two characters");
  AST_OVR_SET: assert property (ovf |=> st_reg.overrun)
    else $error("overrun not flagged on third character");
  AST_OVR_STALL: assert property (st_reg.overrun |-> !push)
    else $error("character stored during overrun");
  AST_OVR_CLR: assert property (
    !st_reg.rsc[`URAD_RC_REN] ##1 !st_reg.rsc[`URAD_RC_REN]
    |-> !st_reg.overrun)
    else $error("overrun kept with receive disabled");
  AST_BITS: assert property (
    st_reg.rx_state == URAD_DATA |-> st_reg.bit_idx <= last_bit)
    else $error("too many data bits shifted");
  AST_ADDR: assert property (
    done && st_reg.rsc[`URAD_RC_AEN] && !ninth |-> !push && !ovf)
    else $error("non-address character accepted");
  AST_ADDR_NINTH: assert property (
    push && st_reg.rsc[`URAD_RC_AEN] |-> entry.data[8])
    else $error("stored address character lacks ninth bit");
  AST_READY_SET: assert property (
    push |=> st_reg.rx_ready || !st_reg.rsc[`URAD_RC_PEN])
    else $error("ready flag not set after store");
  AST_IRQ: assert property (
    st_reg.irq |-> st_reg.rx_ie && st_reg.count != 2'h0)
    else $error("interrupt without enable or data");
  AST_READY: assert property (
    st_reg.rx_ready |-> st_reg.count != 2'h0)
    else $error("ready flag with empty buffer");
  AST_START: assert property (
    st_reg.rx_state == URAD_START && st_reg.tick &&
    st_reg.tcnt == `URAD_T_HALF && rx_line |=> st_reg.rx_state == URAD_IDLE)
    else $error("false start not abandoned");
  AST_FRAME_ERR: assert property (
    push |=> st_reg.fifo[$past(wr_idx)].frame_err == $past(!vote))
    else $error("framing status not stored with its character");
  AST_STEP: assert property (
    st_reg.rx_state == URAD_DATA && $past(st_reg.rx_state) == URAD_DATA &&
    st_reg.bit_idx != $past(st_reg.bit_idx) |-> $past(st_reg.tcnt) == 4'hf)
    else $error("bit advanced off the sixteenth tick");
  AST_IDLE: assert property (!en |=> st_reg.rx_state == URAD_IDLE)
    else $error("sampler active while disabled");

  COV_OVERRUN: cover property (ovf);
  COV_ADDR_DROP: cover property (done && st_reg.rsc[`URAD_RC_AEN] && !ninth);
  COV_FULL_POP: cover property (st_reg.count == 2'h2 ##[1:50] pop);
  COV_FRAME_ERR: cover property (push && entry.frame_err);

endmodule : urad_receiver
`default_nettype wire

// File: logic/urad_regs.svh
/*
  Offsets, field positions, write masks and timing counts of the serial
  receiver with address detection. Assumes byte addresses on AXI4-Lite.
*/
`ifndef URAD_REGS_SVH
`define URAD_REGS_SVH
`define URAD_OFF_RSC    8'h00
`define URAD_OFF_RDATA  8'h04
`define URAD_OFF_TSC    8'h08
`define URAD_OFF_BCTL   8'h0c
`define URAD_OFF_DIVL   8'h10
`define URAD_OFF_DIVH   8'h14
`define URAD_OFF_INTCTL 8'h18
`define URAD_RC_PEN  7
`define URAD_RC_NINE 6
`define URAD_RC_REN  4
`define URAD_RC_AEN  3
`define URAD_TX_SYNC   4
`define URAD_TX_TRMT   1
`define URAD_BC_IDLE   6
`define URAD_BC_WIDE   3
`define URAD_RSC_WMASK  8'hf8
`define URAD_TSC_WMASK  8'hfd
`define URAD_BCTL_WMASK 8'h1b
`define URAD_RESP_OKAY   2'h0
`define URAD_RESP_SLVERR 2'h2
`define URAD_FIFO_DEPTH  2'h2
`define URAD_T_VOTE_A    4'h7
`define URAD_T_VOTE_B    4'h8
`define URAD_T_VOTE_C    4'h9
`define URAD_T_HALF      4'h8
`define URAD_T_LAST      4'hf
`define URAD_LAST_BIT9   4'h8
`define URAD_LAST_BIT8   4'h7
`endif

// File: logic/urad_pkg.sv
/*
  Types of the serial receiver: bus carriers, buffer entry, receiver
  states and the whole state record. Assumes nothing of its surroundings.
*/
package urad_pkg;
  typedef enum logic [1:0] {
    URAD_IDLE  = 2'b00,
    URAD_START = 2'b01,
    URAD_DATA  = 2'b10,
    URAD_STOP  = 2'b11
  } urad_state_type;

  typedef struct packed {
    logic       frame_err;
    logic [8:0] data;
  } urad_entry_type;

  typedef struct packed {
    logic        awvalid;
    logic [7:0]  awaddr;
    logic        wvalid;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        bready;
    logic        arvalid;
    logic [7:0]  araddr;
    logic        rready;
  } urad_axi_req_type;

  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } urad_axi_rsp_type;

  typedef struct packed {
    urad_axi_rsp_type      axi;
    logic                  aw_have;
    logic                  w_have;
    logic [7:0]            waddr;
    logic [7:0]            wbyte;
    logic                  wen0;
    logic [7:0]            rsc;
    logic [7:0]            tsc;
    logic [7:0]            bctl;
    logic [15:0]           divisor;
    logic                  rx_ie;
    logic [15:0]           brg_cnt;
    logic                  tick;
    urad_state_type        rx_state;
    logic [3:0]            tcnt;
    logic [3:0]            bit_idx;
    logic [1:0]            votes;
    logic [8:0]            shift;
    logic                  rx_prev;
    urad_entry_type [1:0]  fifo;
    logic                  rd_ptr;
    logic [1:0]            count;
    logic                  overrun;
    logic                  rx_ready;
    logic                  irq;
  } urad_regs_type;
endpackage : urad_pkg

// File: tb/urad_line_tx.sv
/*
  Line model of the remote serial transmitter: idle high, a start bit,
  data bits least significant first, one stop bit, and a short false
  start on request. Assumes its tasks are called just after a rising edge.
*/
`timescale 1ns/10ps
`default_nettype none
module urad_line_tx #(
  parameter int CYC_PER_BIT = 32
) (
  input  wire logic core_clk,
  output var  logic tx_line
);
  // The line rests high between frames, as an idle transmitter keeps it.
  initial begin
    tx_line = 1'b1;
  end

  // Drives one level for a whole number of clock cycles.
  task automatic hold(input logic lvl, input int cycles);
    tx_line <= lvl;
    repeat (cycles) @(posedge core_clk);
  endtask : hold

  // Sends one frame; a low stop level makes a framing fault on purpose.
  task automatic send(input logic [8:0] d,
                      input int         nbits,
                      input logic       stop_lvl);
    hold(1'b0, CYC_PER_BIT);
    for (int i = 0; i < nbits; i++) begin
      hold(d[i], CYC_PER_BIT);
    end
    hold(stop_lvl, CYC_PER_BIT);
    // A low stop leaves no falling edge for the next start, so rest high.
    if (stop_lvl == 1'b0) begin
      hold(1'b1, CYC_PER_BIT);
    end
  endtask : send

  // A low pulse far shorter than half a bit, which must start nothing.
  task automatic glitch();
    hold(1'b0, CYC_PER_BIT / 8);
    hold(1'b1, CYC_PER_BIT * 2);
  endtask : glitch
endmodule : urad_line_tx
`default_nettype wire

// File: tb/test_async_uart_receiver_addr_detect.sv
/*
  Self-checking bench of the serial receiver: AXI4-Lite register tasks,
  frames from the line model, and compares on status, data and irq.
  Assumes urad_pkg, urad_regs.svh and urad_line_tx are compiled first.
*/
`timescale 1ns/10ps
`default_nettype none
`include "urad_regs.svh"
module test_async_uart_receiver_addr_detect
  import urad_pkg::*;
;
  localparam int CPB = 32; // Divisor low byte 1: two cycles a tick.
  logic             core_clk;
  logic             reset;
  urad_axi_req_type req;
  urad_axi_rsp_type rsp;
  logic             line;
  logic             irq;
  int               failures;
  int               n_tests;
  logic [31:0]      rd;
  logic [1:0]       resp;

  urad_receiver uut (
    .core_clk (core_clk),
    .reset    (reset),
    .axi_req  (req),
    .axi_rsp  (rsp),
    .rx_line  (line),
    .rx_irq   (irq)
  );

  urad_line_tx #(.CYC_PER_BIT(CPB)) far_end (
    .core_clk (core_clk),
    .tx_line  (line)
  );

  // Free-running 100 MHz clock.
  initial core_clk = 1'b0;
  always #5 core_clk = ~core_clk;

  // Prints the counts and the verdict, then ends the run.
  task automatic report_and_stop();
    $display("comparisons %0d, mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : report_and_stop

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic timed_out();
    failures++;
    $display("mismatch at %0t: no bus answer", $time);
    report_and_stop();
  endtask : timed_out

  // Readies are only sampled at edges; bready and rready stay high.
  task automatic axi_write(input logic [7:0] a, input logic [7:0] d);
    int n;
    n = 0;
    req.awvalid <= 1'b1;
    req.awaddr  <= a;
    req.wvalid  <= 1'b1;
    req.wdata   <= {24'h000000, d};
    do begin
      @(posedge core_clk);
      n++;
      if (rsp.awready === 1'b1) req.awvalid <= 1'b0;
      if (rsp.wready === 1'b1) req.wvalid <= 1'b0;
    end while (rsp.bvalid !== 1'b1 && n < 100);
    check({30'h0, rsp.bresp}, {30'h0, `URAD_RESP_OKAY});
    if (rsp.bvalid !== 1'b1) timed_out();
  endtask : axi_write

  task automatic axi_read(input logic [7:0] a);
    int n;
    n = 0;
    req.arvalid <= 1'b1;
    req.araddr  <= a;
    do begin
      @(posedge core_clk);
      n++;
      if (rsp.arready === 1'b1) req.arvalid <= 1'b0;
    end while (rsp.rvalid !== 1'b1 && n < 100);
    rd   = rsp.rdata;
    resp = rsp.rresp;
    if (rsp.rvalid !== 1'b1) timed_out();
  endtask : axi_read

  task automatic expect_reg(input logic [7:0] a, input logic [31:0] exp);
    axi_read(a);
    check({30'h0, resp}, {30'h0, `URAD_RESP_OKAY});
    check(rd, exp);
  endtask : expect_reg

  // Status first, then the data byte, which advances the buffer.
  task automatic rx_pop(input logic [7:0] stat, input logic [7:0] byt);
    expect_reg(`URAD_OFF_RSC, {24'h000000, stat});
    expect_reg(`URAD_OFF_RDATA, {24'h000000, byt});
  endtask : rx_pop

  task automatic done(input string name);
    $display("test done: %s", name);
  endtask : done

  // Main sequence; every register access starts just after an edge.
  initial begin
    failures    = 0;
    n_tests     = 0;
    reset       = 1'b1;
    req         = '0;
    req.wstrb   = 4'h1;
    req.bready  = 1'b1;
    req.rready  = 1'b1;
    repeat (4) @(posedge core_clk);
    reset <= 1'b0;
    repeat (2) @(posedge core_clk);
    expect_reg(`URAD_OFF_RSC, 32'h00000000);
    expect_reg(`URAD_OFF_TSC, 32'h00000002);
    expect_reg(`URAD_OFF_BCTL, 32'h00000040);
    axi_read(8'h1c);
    check({30'h0, resp}, {30'h0, `URAD_RESP_SLVERR});
    check(rd, 32'h00000000);
    axi_write(`URAD_OFF_DIVL, 8'h01);
    axi_write(`URAD_OFF_DIVH, 8'h00);
    expect_reg(`URAD_OFF_DIVL, 32'h00000001);
    done("reset and map");

    axi_write(`URAD_OFF_RSC, 8'h80);
    axi_write(`URAD_OFF_INTCTL, 8'h01);
    axi_write(`URAD_OFF_RSC, 8'h90);
    far_end.send(9'h1a5, 8, 1'b1);
    check({31'h0, irq}, 32'h00000001);
    expect_reg(`URAD_OFF_INTCTL, 32'h00000003);
    rx_pop(8'h90, 8'ha5);
    expect_reg(`URAD_OFF_INTCTL, 32'h00000001);
    check({31'h0, irq}, 32'h00000000);
    done("eight-bit character");

    // Pass 0 drains and clears receive enable; pass 1 drops the port.
    for (int pass = 0; pass < 2; pass++) begin
      axi_write(`URAD_OFF_RSC, 8'hd0);
      far_end.glitch();
      far_end.send(9'h13c, 9, 1'b1);
      far_end.send(9'h0c3, 9, 1'b0);
      far_end.send(9'h155, 9, 1'b1);
      far_end.send(9'h0aa, 9, 1'b1);
      if (pass == 0) begin
        rx_pop(8'hd3, 8'h3c);
        rx_pop(8'hd6, 8'hc3);
        expect_reg(`URAD_OFF_RSC, 32'h000000d2);
        axi_write(`URAD_OFF_RSC, 8'hc0);
        expect_reg(`URAD_OFF_RSC, 32'h000000c0);
      end else begin
        axi_write(`URAD_OFF_RSC, 8'h40);
        expect_reg(`URAD_OFF_RSC, 32'h00000040);
        expect_reg(`URAD_OFF_INTCTL, 32'h00000001);
      end
      done("buffer and overrun");
    end

    axi_write(`URAD_OFF_INTCTL, 8'h00);
    axi_write(`URAD_OFF_RSC, 8'hc0);
    axi_write(`URAD_OFF_RSC, 8'hc8);
    axi_write(`URAD_OFF_RSC, 8'hd8);
    far_end.send(9'h011, 9, 1'b1);
    far_end.send(9'h142, 9, 1'b1);
    check({31'h0, irq}, 32'h00000000);
    expect_reg(`URAD_OFF_INTCTL, 32'h00000002);
    rx_pop(8'hd9, 8'h42);
    expect_reg(`URAD_OFF_INTCTL, 32'h00000000);
    axi_write(`URAD_OFF_RSC, 8'hd0);
    far_end.send(9'h077, 9, 1'b1);
    rx_pop(8'hd0, 8'h77);
    axi_write(`URAD_OFF_RSC, 8'hd8);
    far_end.send(9'h099, 9, 1'b1);
    expect_reg(`URAD_OFF_RSC, 32'h000000d8);
    done("address detection");
    report_and_stop();
  end
endmodule : test_async_uart_receiver_addr_detect
`default_nettype wire
